//--- rtl/csic_top.sv
// socket interrupt and general control registers with status change flags
`timescale 1ns/1ps
// Overview of operation
// - control bit 7 turns the battery-detect pin into the ring input.
// - card reset output asserted while control bit 6 is zero.
// - control bit 5 chooses memory card (0) or I/O card (1).
// - control bit 4 sends status change interrupts to pci, else config select field.
// - bits 3..0 route the card interrupt: none, IRQ1, SYSTEM_MANAGEMENT_INTERRUPT, IRQ3..IRQ15.
// - control register resets to all zeros.
// - a flag whose source is disabled always reads zero.
// - enabled sources set their flag and raise the routed interrupt.
// - flags clear by reading the register or writing one to the bit.
// - an external mode bit picks clear-on-read or write-one-to-clear.
// - flag register is read-only storage and resets to zero.
// - bit 3 flags a change on either card detect; bits 7..4 read zero.
// - bit 2 flags a ready rise on memory cards; zero for I/O cards.
// - bit 1 flags battery warning on memory cards with ring off; zero for I/O cards.
// - bit 0 flags battery dead, I/O status change, or ring when enabled.
module csic_top import csic_pkg::*; (
  input wire logic i_mclk,                      // 200 MHz clock
  input wire logic i_srst,                      // synchronous reset, active high
  input wire logic i_ce,                        // clock enable, freezes state when low
  input wire logic [ADDR_W-1:0] i_addr,         // register byte address
  input wire logic i_wr,                        // write strobe
  input wire logic i_rd,                        // read strobe
  input wire logic [7:0] i_wdata,               // write data
  output logic [7:0] o_rdata,                   // read data, valid with o_rd_valid
  output logic o_rd_valid,                      // one cycle after a read strobe
  input wire logic i_clear_on_write,            // flag clear mode: 1 write-one, 0 on read
  input wire logic i_card_detect_first_n,       // first card detect, low when seated
  input wire logic i_card_detect_second_n,      // second card detect, low when seated
  input wire logic i_card_ready,                // card ready level
  input wire logic i_battery_detect_ring_pin,   // battery detect one or ring input
  input wire logic i_battery_detect_second,     // battery detect two
  input wire logic i_card_status_change,        // I/O card status change signal
  input wire logic i_card_irq,                  // I/O card functional interrupt, high active
  output logic o_card_reset,                    // card reset, high asserted
  output logic o_card_kind_io,                  // 1 when an I/O card is selected
  output logic o_ring_indicate_enable,          // ring function of the shared pin on
  output logic [IRQ_LINES-1:0] o_irq_lines,     // legacy lines, bit n is IRQn
  output logic o_system_management_interrupt,   // smi request
  output logic o_pci_int                        // pci interrupt request
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cfg;
    logic [FLAG_W-1:0] flags;
    logic [1:0] prev_detect;
    logic prev_ready;
    logic [1:0] prev_bvd;
    logic prev_stschg;
    logic primed;
    logic [7:0] rdata;
    logic rd_valid;
    logic [IRQ_LINES-1:0] irq;
    logic system_management_interrupt;
    logic pci;
  } csic_state_t;

  csic_state_t st_reg;
  csic_state_t st_next;

  // edge helpers for the sampled card pins
  function automatic logic csic_rise(input logic now_v, input logic prev_v);
    return now_v && !prev_v;
  endfunction

  function automatic logic csic_fall(input logic now_v, input logic prev_v);
    return !now_v && prev_v;
  endfunction

  // one-hot register decode shared by the write and clear paths
  function automatic logic [2:0] csic_hit(input logic [ADDR_W-1:0] a);
    logic [2:0] h;
    h = 3'h0;
    h[0] = a == ADDR_CTRL;
    h[1] = a == ADDR_FLAGS;
    h[2] = a == ADDR_CFG;
    return h;
  endfunction

  csic_route_if rt ();

  csic_router u_router (
    .rt(rt)
  );

  logic ring_en;
  logic kind_io;
  logic [FLAG_W-1:0] enables;
  logic [FLAG_W-1:0] visible;
  logic [FLAG_W-1:0] set_ev;
  logic [FLAG_W-1:0] clr_ev;
  logic [1:0] detect_now;
  logic [1:0] bvd_now;
  logic ready_rise;
  logic warn_entry;
  logic dead_entry;
  logic stschg_rise;
  logic ring_fall;
  logic bit0_src;
  logic [2:0] reg_hit;

  assign ring_en = st_reg.ctrl[CTRL_RING_EN_BIT];
  assign kind_io = st_reg.ctrl[CTRL_KIND_IO_BIT];
  assign enables = st_reg.cfg[FLAG_W-1:0];
  assign detect_now = {i_card_detect_second_n, i_card_detect_first_n};
  assign bvd_now = {i_battery_detect_ring_pin, i_battery_detect_second};
  assign reg_hit = csic_hit(i_addr);

  // flags of disabled sources and memory-only flags on I/O cards are hidden
  always_comb begin
    visible = st_reg.flags & enables;
    if (kind_io) begin
      visible[FLAG_READY_BIT] = 1'b0;
      visible[FLAG_WARN_BIT] = 1'b0;
    end
  end

  // edges are ignored on the first sample after reset, when history is not yet valid
  always_comb begin
    ready_rise = csic_rise(i_card_ready, st_reg.prev_ready);
    warn_entry = (bvd_now == BVD_WARNING) && (st_reg.prev_bvd != BVD_WARNING);
    dead_entry = csic_fall(bvd_now[1], st_reg.prev_bvd[1]);
    stschg_rise = csic_rise(i_card_status_change, st_reg.prev_stschg);
    ring_fall = csic_fall(bvd_now[1], st_reg.prev_bvd[1]);
    if (ring_en) begin
      bit0_src = ring_fall;
    end else if (kind_io) begin
      bit0_src = stschg_rise;
    end else begin
      bit0_src = dead_entry;
    end
    set_ev = 4'h0;
    set_ev[FLAG_DETECT_BIT] = detect_now != st_reg.prev_detect;
    set_ev[FLAG_READY_BIT] = !kind_io && ready_rise;
    set_ev[FLAG_WARN_BIT] = !kind_io && !ring_en && warn_entry;
    set_ev[FLAG_DEAD_BIT] = bit0_src;
    set_ev = st_reg.primed ? (set_ev & enables) : 4'h0;
  end

  // clear method follows the external mode bit
  always_comb begin
    clr_ev = 4'h0;
    if (reg_hit[1]) begin
      if (!i_clear_on_write && i_rd) begin
        clr_ev = {FLAG_W{1'b1}};
      end else if (i_clear_on_write && i_wr) begin
        clr_ev = i_wdata[FLAG_W-1:0];
      end
    end
  end

  // per-flag next value; a set in the same cycle as a clear is kept
  logic [FLAG_W-1:0] flags_next;
  generate
    for (genvar gi = 0; gi < FLAG_W; gi++) begin : g_flag
      assign flags_next[gi] = enables[gi] && (set_ev[gi] || (st_reg.flags[gi] && !clr_ev[gi]));
    end
  endgenerate

  // route status requests out of registered state; the card interrupt comes from the live i_card_irq pin
  always_comb begin
    rt.status_pending = |visible;
    rt.pci_route = st_reg.ctrl[CTRL_PCI_ROUTE_BIT];
    rt.status_sel = st_reg.cfg[CFG_IRQ_SEL_LSB +: 4];
    rt.card_irq = kind_io && i_card_irq;
    rt.card_sel = st_reg.ctrl[CTRL_IRQ_SEL_LSB +: 4];
  end

  always_comb begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.prev_detect = detect_now;
    st_next.prev_ready = i_card_ready;
    st_next.prev_bvd = bvd_now;
    st_next.prev_stschg = i_card_status_change;
    st_next.primed = 1'b1;
    // a set in the same cycle as a clear is kept
    st_next.flags = flags_next;
    if (i_wr && reg_hit[0]) begin
      st_next.ctrl = i_wdata;
    end
    if (i_wr && reg_hit[2]) begin
      st_next.cfg = i_wdata;
    end
    if (i_rd) begin
      st_next.rd_valid = 1'b1;
      unique case (i_addr)
        ADDR_CTRL: st_next.rdata = st_reg.ctrl;
        ADDR_CFG: st_next.rdata = st_reg.cfg;
        ADDR_FLAGS: st_next.rdata = {4'h0, visible};
        default: st_next.rdata = 8'h00;
      endcase
    end
    st_next.irq = rt.irq_lines;
    st_next.system_management_interrupt = rt.system_management_interrupt;
    st_next.pci = rt.pci_int;
  end

  // reset overrides the clock enable so a stalled block still comes up clean
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.cfg <= CFG_RESET;
      st_reg.flags <= FLAGS_RESET;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_rd_valid = st_reg.rd_valid;
  assign o_card_reset = !st_reg.ctrl[CTRL_RESET_RELEASE_BIT];
  assign o_card_kind_io = kind_io;
  assign o_ring_indicate_enable = ring_en;
  assign o_irq_lines = st_reg.irq;
  assign o_system_management_interrupt = st_reg.system_management_interrupt;
  assign o_pci_int = st_reg.pci;
endmodule

//--- pkg/csic_pkg.sv
// register map, field positions and reset values for the card socket interrupt block
package csic_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h803;
  localparam logic [11:0] ADDR_FLAGS = 12'h804;
  localparam logic [11:0] ADDR_CFG = 12'h805;

  // card_interrupt_general_control fields
  localparam int CTRL_RING_EN_BIT = 7;
  localparam int CTRL_RESET_RELEASE_BIT = 6;
  localparam int CTRL_KIND_IO_BIT = 5;
  localparam int CTRL_PCI_ROUTE_BIT = 4;
  localparam int CTRL_IRQ_SEL_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // status change configuration fields
  localparam int CFG_IRQ_SEL_LSB = 4;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // card_status_change_flags fields
  localparam int FLAG_W = 4;
  localparam int FLAG_DETECT_BIT = 3;
  localparam int FLAG_READY_BIT = 2;
  localparam int FLAG_WARN_BIT = 1;
  localparam int FLAG_DEAD_BIT = 0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // select code meanings; other codes name the legacy line directly
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_SMI = 4'h2;
  localparam int IRQ_LINES = 16;

  // battery detect pair encodings
  localparam logic [1:0] BVD_WARNING = 2'h2;
endpackage

//--- pkg/csic_route_if.sv
// carrier between the socket register logic and the interrupt router
`timescale 1ns/1ps
interface csic_route_if;
  logic status_pending;
  logic pci_route;
  logic [3:0] status_sel;
  logic card_irq;
  logic [3:0] card_sel;
  logic [15:0] irq_lines;
  logic system_management_interrupt;
  logic pci_int;

  modport ctrl (
    output status_pending, pci_route, status_sel, card_irq, card_sel,
    input irq_lines, system_management_interrupt, pci_int
  );
  modport router (
    input status_pending, pci_route, status_sel, card_irq, card_sel,
    output irq_lines, system_management_interrupt, pci_int
  );
endinterface

//--- rtl/csic_router.sv
// steers functional and status change interrupts onto legacy lines, smi or pci
`timescale 1ns/1ps
module csic_router import csic_pkg::*; (
  csic_route_if.router rt  // requests in, routed lines out
);
  // bit 16 is smi, bits 15..0 are the legacy lines
  function automatic logic [16:0] csic_decode(input logic [3:0] sel, input logic req);
    logic [16:0] v;
    v = 17'h00000;
    if (req && sel != SEL_NONE) begin
      if (sel == SEL_SMI) begin
        v[16] = 1'b1;
      end else begin
        v[sel] = 1'b1;
      end
    end
    return v;
  endfunction

  logic [16:0] card_v;
  logic [16:0] stat_v;

  always_comb begin
    card_v = csic_decode(rt.card_sel, rt.card_irq);
    stat_v = csic_decode(rt.status_sel, rt.status_pending && !rt.pci_route);
    rt.irq_lines = card_v[15:0] | stat_v[15:0];
    rt.system_management_interrupt = card_v[16] | stat_v[16];
    rt.pci_int = rt.status_pending && rt.pci_route;
  end
endmodule

//--- dv/csic_card_model.sv
// behavioural socket card that drives the card side pins
`timescale 1ns/1ps
module csic_card_model (
  input wire logic i_mclk, // pins move 1 ns after this edge
  output logic [6:0] o_pins // detect1_n detect2_n ready bvd1 bvd2 status_change irq
);
  initial o_pins = 7'h0c;
  // one update of the whole pin vector per call, never on the sampling edge itself
  task automatic drive(input logic [6:0] v);
    @(posedge i_mclk);
    #1 o_pins = v;
  endtask
endmodule

//--- dv/csic_top_chk.sv
// bound checks on the socket interrupt block
`timescale 1ns/1ps
module csic_top_chk import csic_pkg::*; (
  input wire logic i_mclk, // clock
  input wire logic i_srst, // reset
  input wire logic i_ce, // enable
  input wire logic [ADDR_W-1:0] i_addr, // address
  input wire logic i_wr, // write
  input wire logic [7:0] i_wdata, // write data
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_rd_valid, // read valid
  input wire logic o_card_reset, // card reset
  input wire logic o_card_kind_io, // io card
  input wire logic o_ring_indicate_enable, // ring on
  input wire logic o_system_management_interrupt, // smi
  input wire logic o_pci_int // pci
);
  logic [7:0] ctrl_reg;
  logic [7:0] cfg_reg;
  // shadows so route checks know what the host programmed
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctrl_reg <= CTRL_RESET;
      cfg_reg <= CFG_RESET;
    end else if (i_ce && i_wr && i_addr == ADDR_CTRL) begin
      ctrl_reg <= i_wdata;
    end else if (i_ce && i_wr && i_addr == ADDR_CFG) begin
      cfg_reg <= i_wdata;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_reset_defaults: assert property ($fell(i_srst) |-> o_card_reset && !o_card_kind_io && !o_pci_int)
    else $error("outputs not at reset values");
  a_ring_follows: assert property (i_ce && i_wr && i_addr == ADDR_CTRL |=> o_ring_indicate_enable == $past(i_wdata[7]))
    else $error("ring enable does not follow write");
  a_reset_follows: assert property (i_ce && i_wr && i_addr == ADDR_CTRL |=> o_card_reset != $past(i_wdata[6]))
    else $error("card reset does not follow write");
  a_flags_high_zero: assert property (o_rd_valid && $past(i_addr) == ADDR_FLAGS |-> o_rdata[7:4] == 4'h0)
    else $error("flag read upper bits set");
  a_io_bits_zero: assert property (o_rd_valid && $past(i_addr) == ADDR_FLAGS && $past(o_card_kind_io) |-> o_rdata[2:1] == 2'h0)
    else $error("io card flag bits 2..1 set");
  a_disabled_zero: assert property (o_rd_valid && $past(i_addr) == ADDR_FLAGS |-> (o_rdata[3:0] & ~$past(cfg_reg[3:0])) == 4'h0)
    else $error("disabled flag reads one");
  a_pci_gated: assert property (!$past(ctrl_reg[4]) |-> !o_pci_int)
    else $error("pci request while not routed");
  a_smi_source: assert property (o_system_management_interrupt |-> $past(ctrl_reg[3:0]) == SEL_SMI ||
    ($past(cfg_reg[7:4]) == SEL_SMI && !$past(ctrl_reg[4])))
    else $error("smi without smi select");
  a_freeze_holds: assert property (!i_ce |=> $stable(o_rdata) && $stable(o_rd_valid) && $stable(o_card_reset) &&
    $stable(o_card_kind_io) && $stable(o_ring_indicate_enable) && $stable(o_system_management_interrupt) &&
    $stable(o_pci_int))
    else $error("outputs moved while clock enable low");
endmodule
bind csic_top csic_top_chk u_chk (.*);

//--- dv/tb_csic_top.sv
// self-checking bench for the socket interrupt block
`timescale 1ns/1ps
module tb_csic_top import csic_pkg::*; ;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_ce = 1'b1;
  logic i_clear_on_write = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic o_rd_valid;
  logic o_card_reset;
  logic o_card_kind_io;
  logic o_ring_indicate_enable;
  logic o_system_management_interrupt;
  logic o_pci_int;
  logic [15:0] o_irq_lines;
  logic [6:0] pins;
  int bad_count = 0;
  int cmp_count = 0;
  always #2.5 i_mclk = ~i_mclk;
  csic_card_model i_card (.i_mclk(i_mclk), .o_pins(pins));
  csic_top i_dut (.i_ce(i_ce), .i_card_detect_first_n(pins[6]), .i_card_detect_second_n(pins[5]),
    .i_card_ready(pins[4]), .i_battery_detect_ring_pin(pins[3]), .i_battery_detect_second(pins[2]),
    .i_card_status_change(pins[1]), .i_card_irq(pins[0]), .*);
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1 i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(posedge i_mclk);
    #1 i_wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    #1 i_addr = a;
    i_rd = 1'b1;
    @(posedge i_mclk);
    #1 i_rd = 1'b0;
    chk("rd_valid", 16'(o_rd_valid), 16'h0001);
    chk("rdata", 16'(o_rdata), 16'(e));
  endtask
  // one edge to flag, one to route, one spare
  task automatic ev(input logic [6:0] v);
    i_card.drive(v);
    repeat (3) @(posedge i_mclk);
    #1;
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    results();
  end
  initial begin
    repeat (3) @(posedge i_mclk);
    #1 i_srst = 1'b0;
    chk("outs", 16'({o_ring_indicate_enable, o_card_reset, o_card_kind_io}), 16'h0002);
    reg_rd(ADDR_CTRL, 8'h00);
    reg_rd(ADDR_FLAGS, 8'h00);
    reg_rd(12'h806, 8'h00);
    reg_wr(ADDR_CTRL, 8'he0);
    chk("outs", 16'({o_ring_indicate_enable, o_card_reset, o_card_kind_io}), 16'h0005);
    reg_rd(ADDR_CTRL, 8'he0);
    reg_wr(ADDR_CTRL, 8'h40);
    reg_wr(ADDR_CFG, 8'h58);
    ev(7'h4c);
    chk("irq", o_irq_lines, 16'h0020);
    ev(7'h5c);
    reg_rd(ADDR_FLAGS, 8'h08);
    reg_rd(ADDR_FLAGS, 8'h00);
    ev(7'h5c);
    chk("irq", o_irq_lines, 16'h0000);
    i_clear_on_write = 1'b1;
    ev(7'h0c);
    reg_rd(ADDR_FLAGS, 8'h08);
    reg_rd(ADDR_FLAGS, 8'h08);
    reg_wr(ADDR_FLAGS, 8'h08);
    reg_rd(ADDR_FLAGS, 8'h00);
    reg_wr(ADDR_CTRL, 8'h50);
    ev(7'h4c);
    chk("pci", 16'(o_pci_int), 16'h0001);
    chk("irq", o_irq_lines, 16'h0000);
    reg_wr(ADDR_FLAGS, 8'h08);
    reg_wr(ADDR_CTRL, 8'h40);
    reg_wr(ADDR_CFG, 8'h27);
    ev(7'h5c);
    ev(7'h58);
    ev(7'h50);
    chk("smi", 16'(o_system_management_interrupt), 16'h0001);
    reg_rd(ADDR_FLAGS, 8'h07);
    reg_wr(ADDR_CTRL, 8'h60);
    reg_rd(ADDR_FLAGS, 8'h01);
    reg_wr(ADDR_FLAGS, 8'h07);
    reg_rd(ADDR_FLAGS, 8'h00);
    reg_wr(ADDR_CTRL, 8'he0);
    ev(7'h58);
    ev(7'h50);
    reg_rd(ADDR_FLAGS, 8'h01);
    reg_wr(ADDR_FLAGS, 8'h01);
    reg_wr(ADDR_CTRL, 8'h60);
    ev(7'h52);
    reg_rd(ADDR_FLAGS, 8'h01);
    chk("smi", 16'(o_system_management_interrupt), 16'h0001);
    reg_wr(ADDR_CFG, 8'h00);
    for (int c = 0; c < 16; c++) begin
      reg_wr(ADDR_CTRL, 8'h60 | 8'(c));
      ev(7'h51);
      chk("lines", o_irq_lines, (c == 0 || c == 2) ? 16'h0000 : 16'h0001 << c);
      chk("smi", 16'(o_system_management_interrupt), 16'(c == 2));
    end
    i_ce = 1'b0;
    reg_wr(ADDR_CTRL, 8'h00);
    i_ce = 1'b1;
    chk("frozen", 16'({o_ring_indicate_enable, o_card_reset, o_card_kind_io}), 16'h0001);
    chk("frozen irq", o_irq_lines, 16'h8000);
    reg_rd(ADDR_CTRL, 8'h6f);
    results();
  end
endmodule
